//--- hdl/sdci_ctrl.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps

// Functional notes
// - estop active: servo off, dynamic brake stops motor
// - while estop active every operation command is rejected
// - estop: driver ready opens, alarm F4, servo off
// - estop pin must be off over 1 ms before it counts
// - estop polarity normally closed by default, normally open selectable
// - warning clear rising edge clears warning; falling edge ignored
// - after clear, servo returns to prior state unless request changed since
// - A3 C0 F1 P5 servo off; F5 F8 cycle stop; A5 no change
// - cw limit is clockwise, ccw limit counter-clockwise, never inverted
// - limit hit in running direction: stop at once, servo locked, F3
// - in overtravel only moves away from the limit are accepted
// - overtravel opens plus or minus entry flag
// - overtravel latched until motor leaves the forbidden area
// - escape command moves opposite to entry direction
// - servo request enables servo only with both supplies and ready
// - servo state reported after 3.2 s first time, 170 ms later
// - request off: servo off, dynamic brake, clear position error counter
// - motor off command disables servo enabled by request
// - servo on command re-enables servo disabled by motor off
// - main power lost while servo on raises P5
// - program start rising edge starts selected channel; falling ignored
// - start refused with F5 when busy, bad channel, unmet, alarm, stop
// - warning output open on warning, clearable without power cycle
module sdci_ctrl #(
    parameter logic [sdci_pkg::TW-1:0] P_ESTOP_CYC = sdci_pkg::TW'(sdci_pkg::ESTOP_CYC),
    parameter logic [sdci_pkg::TW-1:0] P_FIRST_CYC = sdci_pkg::TW'(sdci_pkg::SV_FIRST_CYC),
    parameter logic [sdci_pkg::TW-1:0] P_LATER_CYC = sdci_pkg::TW'(sdci_pkg::SV_LATER_CYC)
) (
    // clock and reset
    input  wire logic                    i_mclk,
    input  wire logic                    i_rst,
    // register bus
    input  wire sdci_pkg::sdci_axi_req_t i_axi,
    output sdci_pkg::sdci_axi_rsp_t      o_axi,
    // discrete pins
    input  wire sdci_pkg::sdci_pins_t    i_pins,
    // motion and program engine
    input  wire logic                    i_moving,
    input  wire logic                    i_motion_cw,
    input  wire sdci_pkg::sdci_wevt_t    i_warn_evt,
    input  wire logic                    i_prog_busy,
    input  wire logic                    i_chan_ok,
    input  wire logic                    i_prog_cond,
    // status pins
    output logic                         o_driver_ready,
    output logic                         o_warning,
    output logic                         o_servo_state,
    output logic                         o_plus_entry_flag,
    output logic                         o_minus_entry_flag,
    // motion and program commands
    output logic                         o_dyn_brake,
    output logic                         o_err_clr,
    output logic                         o_cycle_stop,
    output logic                         o_motor_stop,
    output logic                         o_prog_start,
    output logic [7:0]                   o_prog_chan,
    output logic                         o_move_go,
    output logic                         o_move_cw
);
    import sdci_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [PW-1:0] s1;
        logic [PW-1:0] s2;
        logic [PW-1:0] s3;
        logic [PW-1:0] flt;
        logic [PW-1:0] fltp;
        logic [TW-1:0] est_cnt;
        logic          estop;
        sdci_cfg_t     cfg;
        logic          ot_cw;
        logic          ot_ccw;
        logic          plus;
        logic          minus;
        sdci_code_t    warn;
        logic          sv_save;
        logic          req_chg;
        logic          sv_want;
        logic          mo_off;
        logic          sv_state;
        logic          first_done;
        logic [TW-1:0] sv_cnt;
        logic          dbrake;
        logic          err_clr;
        logic          cyc_stop;
        logic          mstop;
        logic          prog_go;
        logic [7:0]    prog_ch;
        logic          move_go;
        logic          move_cw;
        logic          aw_have;
        logic [AW-1:0] aw_addr;
        logic          w_have;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          awrdy;
        logic          wrdy;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arrdy;
        logic          rvalid;
        logic [31:0]   rdata;
        logic [1:0]    rresp;
    } sdci_st_t;

    sdci_st_t q;
    sdci_st_t n;

    sdci_pins_t p;
    sdci_pins_t pp;
    sdci_cmd_t  cmd;
    sdci_stat_t stat;
    sdci_code_t new_w;
    logic       est_raw;
    logic       cw_lim;
    logic       ccw_lim;
    logic       alarm;
    logic       en_ok;
    logic       off_cls;
    logic       wr_fire;
    logic [PW-1:0] agree;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = q;

        // three-stage sync; a change counts once stages 2 and 3 agree
        agree  = ~(q.s2 ^ q.s3);
        n.s1   = i_pins;
        n.s2   = q.s1;
        n.s3   = q.s2;
        n.flt  = (agree & q.s3) | (~agree & q.flt);
        n.fltp = q.flt;
        p      = sdci_pins_t'(q.flt);
        pp     = sdci_pins_t'(q.fltp);

        // register write decode
        wr_fire = q.aw_have & q.w_have & ~q.bvalid;
        cmd     = '0;
        if (wr_fire && q.wstrb[0]) begin
            if (q.aw_addr == ADDR_CFG) begin
                n.cfg = sdci_cfg_t'(q.wdata[$bits(sdci_cfg_t)-1:0]);
            end else if (q.aw_addr == ADDR_CMD) begin
                cmd = sdci_cmd_t'(q.wdata[$bits(sdci_cmd_t)-1:0]);
            end
        end

        // emergency stop, filtered against short pulses
        est_raw = p.emergency_stop ^ ~q.cfg.estop_no;
        if (!est_raw) begin
            n.est_cnt = '0;
            n.estop   = 1'b0;
        end else if (q.est_cnt == P_ESTOP_CYC) begin
            n.estop   = 1'b1;
        end else begin
            n.est_cnt = q.est_cnt + TW'(1);
        end

        // hardware travel limits; direction inversion does not remap
        cw_lim  = p.cw_limit ^ ~q.cfg.cw_no;
        ccw_lim = p.ccw_limit ^ ~q.cfg.ccw_no;
        n.mstop = 1'b0;
        if (cw_lim && i_moving && i_motion_cw) begin
            n.ot_cw = 1'b1;
            n.mstop = 1'b1;
        end else if (!cw_lim) begin
            n.ot_cw = 1'b0;
        end
        if (ccw_lim && i_moving && !i_motion_cw) begin
            n.ot_ccw = 1'b1;
            n.mstop  = 1'b1;
        end else if (!ccw_lim) begin
            n.ot_ccw = 1'b0;
        end
        // entry flags follow the counting direction, not the switch
        n.plus  = q.cfg.dir_invert ? n.ot_ccw : n.ot_cw;
        n.minus = q.cfg.dir_invert ? n.ot_cw : n.ot_ccw;

        alarm   = q.estop | q.ot_cw | q.ot_ccw;
        off_cls = (q.warn == CODE_A3) || (q.warn == CODE_C0)
               || (q.warn == CODE_F1) || (q.warn == CODE_P5);
        en_ok   = ~q.estop & p.main_power & p.ctrl_power & ~off_cls;

        // program start on rising edge only
        n.prog_go = 1'b0;
        new_w     = CODE_NONE;
        if (p.program_start && !pp.program_start) begin
            if (i_prog_busy || !i_chan_ok || !i_prog_cond || alarm
                || (q.warn != CODE_NONE) || p.stop) begin
                new_w = CODE_F5;
            end else begin
                n.prog_go = 1'b1;
                n.prog_ch = p.channel_select;
            end
        end

        // warning sources, first one wins when several coincide; F5 from a refused start beats only A5
        if (pp.main_power && !p.main_power && q.sv_state) begin
            new_w = CODE_P5;
        end else if (i_warn_evt.a3) begin
            new_w = CODE_A3;
        end else if (i_warn_evt.c0) begin
            new_w = CODE_C0;
        end else if (i_warn_evt.f1) begin
            new_w = CODE_F1;
        end else if (i_warn_evt.f8) begin
            new_w = CODE_F8;
        end else if (i_warn_evt.a5 && new_w == CODE_NONE) begin
            new_w = CODE_A5;
        end

        // request edges seen while a warning holds block the restore
        if (p.servo_request != pp.servo_request) begin
            n.req_chg = 1'b1;
        end

        // servo request and serial servo commands
        n.err_clr = 1'b0;
        if (p.servo_request && !pp.servo_request && en_ok && !alarm) begin
            n.sv_want = 1'b1;
            n.mo_off  = 1'b0;
        end
        if (!p.servo_request && pp.servo_request) begin
            n.sv_want = 1'b0;
            n.mo_off  = 1'b0;
            n.err_clr = 1'b1;
        end
        if (!q.estop) begin
            if (cmd.motor_off && q.sv_want && p.servo_request) begin
                n.sv_want = 1'b0;
                n.mo_off  = 1'b1;
            end
            if (cmd.servo_on && q.mo_off && en_ok) begin
                n.sv_want = 1'b1;
                n.mo_off  = 1'b0;
            end
        end

        // warning latch; a new warning beats a clear in the same cycle
        if (new_w != CODE_NONE && (q.warn == CODE_NONE
            || (p.warning_clear && !pp.warning_clear))) begin
            n.warn    = new_w;
            n.sv_save = n.sv_want;
            n.req_chg = 1'b0;
            if (new_w == CODE_A3 || new_w == CODE_C0
                || new_w == CODE_F1 || new_w == CODE_P5) begin
                n.sv_want = 1'b0;
            end
        end else if (p.warning_clear && !pp.warning_clear
                     && q.warn != CODE_NONE) begin
            n.warn = CODE_NONE;
            if (off_cls && q.sv_save && !n.req_chg && !q.estop) begin
                n.sv_want = 1'b1;
            end
        end
        n.cyc_stop = (n.warn == CODE_F5) || (n.warn == CODE_F8);

        // emergency stop overrides everything
        if (q.estop) begin
            n.sv_want = 1'b0;
            n.mo_off  = 1'b0;
        end

        // servo settling: long on the first enable after power-up
        if (!n.sv_want) begin
            n.sv_state = 1'b0;
            n.sv_cnt   = '0;
        end else if (!q.sv_state) begin
            if (q.sv_cnt == (q.first_done ? P_LATER_CYC : P_FIRST_CYC)) begin
                n.sv_state   = 1'b1;
                n.first_done = 1'b1;
            end else begin
                n.sv_cnt = q.sv_cnt + TW'(1);
            end
        end
        n.dbrake = ~n.sv_want;

        // positioning commands; overtravel allows only the way out
        n.move_go = 1'b0;
        if (!q.estop && !p.stop && q.sv_state) begin
            if (cmd.escape && (q.ot_cw || q.ot_ccw)) begin
                n.move_go = 1'b1;
                n.move_cw = q.ot_ccw;
            end else if (cmd.move && !(q.ot_cw && cmd.move_cw)
                         && !(q.ot_ccw && !cmd.move_cw)) begin
                n.move_go = 1'b1;
                n.move_cw = cmd.move_cw;
            end
        end

        // AXI4-Lite write channel
        if (i_axi.awvalid && q.awrdy) begin
            n.aw_have = 1'b1;
            n.aw_addr = i_axi.awaddr;
        end
        if (i_axi.wvalid && q.wrdy) begin
            n.w_have = 1'b1;
            n.wdata  = i_axi.wdata;
            n.wstrb  = i_axi.wstrb;
        end
        if (q.bvalid && i_axi.bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_fire) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = (q.aw_addr == ADDR_CFG || q.aw_addr == ADDR_CMD
                         || q.aw_addr == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
        end
        n.awrdy = ~n.aw_have & ~n.bvalid;
        n.wrdy  = ~n.w_have & ~n.bvalid;

        // status word, read side
        stat         = '0;
        stat.servo   = q.sv_state;
        stat.ready   = ~q.estop;
        stat.warn_on = q.warn != CODE_NONE;
        stat.plus    = q.plus;
        stat.minus   = q.minus;
        stat.estop   = q.estop;
        stat.ot_cw   = q.ot_cw;
        stat.ot_ccw  = q.ot_ccw;
        stat.warn    = q.warn;
        stat.alarm   = q.estop ? CODE_F4
                     : ((q.ot_cw || q.ot_ccw) ? CODE_F3 : CODE_NONE);

        // AXI4-Lite read channel
        if (q.rvalid && i_axi.rready) begin
            n.rvalid = 1'b0;
        end
        if (i_axi.arvalid && q.arrdy) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            case (i_axi.araddr)
                ADDR_CFG:  n.rdata = {{(32 - $bits(sdci_cfg_t)){1'b0}}, q.cfg};
                ADDR_CMD:  n.rdata = RD_ZERO;
                ADDR_STAT: n.rdata = stat;
                default: begin
                    n.rdata = RD_ZERO;
                    n.rresp = RESP_SLVERR;
                end
            endcase
        end
        n.arrdy = ~n.rvalid;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            q          <= '0;
            q.cfg      <= CFG_RST;
            q.warn     <= CODE_NONE;
            q.dbrake   <= 1'b1;
            q.awrdy    <= 1'b1;
            q.wrdy     <= 1'b1;
            q.arrdy    <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // driver ready closes once estop is released, warnings do not open it
    assign o_driver_ready     = ~q.estop;
    assign o_warning          = q.warn != CODE_NONE;
    assign o_servo_state      = q.sv_state;
    assign o_plus_entry_flag  = q.plus;
    assign o_minus_entry_flag = q.minus;
    assign o_dyn_brake        = q.dbrake;
    assign o_err_clr          = q.err_clr;
    assign o_cycle_stop       = q.cyc_stop;
    assign o_motor_stop       = q.mstop;
    assign o_prog_start       = q.prog_go;
    assign o_prog_chan        = q.prog_ch;
    assign o_move_go          = q.move_go;
    assign o_move_cw          = q.move_cw;

    assign o_axi.awready = q.awrdy;
    assign o_axi.wready  = q.wrdy;
    assign o_axi.bvalid  = q.bvalid;
    assign o_axi.bresp   = q.bresp;
    assign o_axi.arready = q.arrdy;
    assign o_axi.rvalid  = q.rvalid;
    assign o_axi.rdata   = q.rdata;
    assign o_axi.rresp   = q.rresp;

endmodule

//--- hdl/sdci_pkg.sv
package sdci_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned ESTOP_MIN_US = 1000;
    localparam int unsigned SV_FIRST_MS  = 3200;  // 3.2 s
    localparam int unsigned SV_LATER_MS  = 170;
    localparam int unsigned ESTOP_CYC    = (ESTOP_MIN_US * CYC_PER_MS + 999) / 1000;
    localparam int unsigned SV_FIRST_CYC = SV_FIRST_MS * CYC_PER_MS;
    localparam int unsigned SV_LATER_CYC = SV_LATER_MS * CYC_PER_MS;
    localparam int          TW           = 27;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int              AW          = 8;
    localparam logic [AW-1:0]   ADDR_CFG    = 8'h00;
    localparam logic [AW-1:0]   ADDR_CMD    = 8'h04;
    localparam logic [AW-1:0]   ADDR_STAT   = 8'h08;
    localparam logic [1:0]      RESP_OKAY   = 2'h0;
    localparam logic [1:0]      RESP_SLVERR = 2'h2;
    localparam logic [31:0]     RD_ZERO     = 32'h0;

    typedef enum logic [3:0] {
        CODE_NONE = 4'h0, CODE_A3 = 4'h1, CODE_A5 = 4'h2, CODE_C0 = 4'h3,
        CODE_F1   = 4'h4, CODE_F5 = 4'h5, CODE_F8 = 4'h6, CODE_P5 = 4'h7,
        CODE_F3   = 4'h8, CODE_F4 = 4'h9
    } sdci_code_t;

    typedef struct packed {
        logic       emergency_stop;
        logic       warning_clear;
        logic       cw_limit;
        logic       ccw_limit;
        logic       servo_request;
        logic       program_start;
        logic       stop;
        logic       main_power;
        logic       ctrl_power;
        logic [7:0] channel_select;
    } sdci_pins_t;
    localparam int PW = $bits(sdci_pins_t);

    typedef struct packed {
        logic a3; logic a5; logic c0; logic f1; logic f8;
    } sdci_wevt_t;

    typedef struct packed {
        logic dir_invert; logic ccw_no; logic cw_no; logic estop_no;
    } sdci_cfg_t;
    localparam sdci_cfg_t CFG_RST = 4'h0;

    typedef struct packed {
        logic move_cw; logic move; logic escape; logic servo_on; logic motor_off;
    } sdci_cmd_t;

    typedef struct packed {
        logic [15:0] rsvd;
        sdci_code_t  warn;
        sdci_code_t  alarm;
        logic ot_ccw; logic ot_cw; logic estop; logic minus;
        logic plus; logic warn_on; logic ready; logic servo;
    } sdci_stat_t;

    typedef struct packed {
        logic          awvalid;
        logic [AW-1:0] awaddr;
        logic          wvalid;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        logic          bready;
        logic          arvalid;
        logic [AW-1:0] araddr;
        logic          rready;
    } sdci_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } sdci_axi_rsp_t;

endpackage

//--- tb/sdci_ctrl_monitor.sv
`timescale 1ns/100ps
module sdci_ctrl_monitor #(
    parameter logic [sdci_pkg::TW-1:0] P_ESTOP_CYC = 8,
    parameter logic [sdci_pkg::TW-1:0] P_FIRST_CYC = 20,
    parameter logic [sdci_pkg::TW-1:0] P_LATER_CYC = 6
) (
    // clock and reset
    input wire logic                 i_mclk,
    input wire logic                 i_rst,
    // watched ports
    input wire sdci_pkg::sdci_pins_t i_pins,
    input wire logic                 i_prog_busy,
    input wire logic                 i_chan_ok,
    input wire logic                 i_prog_cond,
    input wire logic                 o_driver_ready,
    input wire logic                 o_warning,
    input wire logic                 o_servo_state,
    input wire logic                 o_plus_entry_flag,
    input wire logic                 o_minus_entry_flag,
    input wire logic                 o_dyn_brake,
    input wire logic                 o_motor_stop,
    input wire logic                 o_prog_start
);
    import sdci_pkg::*;
    int   est_q, req_q;
    logic est_d1_q, on_q;
    // ages of raw pins, so filter delays only ever add to them
    always_ff @(posedge i_mclk) begin
        est_d1_q <= i_pins.emergency_stop;
        est_q    <= (i_rst || i_pins.emergency_stop != est_d1_q) ? 0 : est_q + 1;
        req_q    <= (i_rst || !i_pins.servo_request) ? 0 : req_q + 1;
        on_q     <= !i_rst && (on_q || o_servo_state);
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_estop_off;
        $fell(o_driver_ready) |=> !o_servo_state && o_dyn_brake;
    endproperty
    a_estop_off: assert property (p_estop_off) else $error("servo on in estop");
    property p_estop_len;
        $fell(o_driver_ready) |-> est_q >= P_ESTOP_CYC;
    endproperty
    a_estop_len: assert property (p_estop_len) else $error("short estop taken");
    property p_estop_lock;
        !o_driver_ready |-> !$rose(o_servo_state);
    endproperty
    a_estop_lock: assert property (p_estop_lock) else $error("servo on in estop");
    property p_sv_time;
        $rose(o_servo_state) |-> req_q >= (on_q ? P_LATER_CYC : P_FIRST_CYC);
    endproperty
    a_sv_time: assert property (p_sv_time) else $error("servo state early");
    property p_clr_rise;
        o_warning && $rose(i_pins.warning_clear) |-> ##[1:10] !o_warning;
    endproperty
    a_clr_rise: assert property (p_clr_rise) else $error("warning not cleared");
    property p_clr_fall;
        o_warning && $fell(i_pins.warning_clear) |=> o_warning [*8];
    endproperty
    a_clr_fall: assert property (p_clr_fall) else $error("cleared on fall");
    property p_prog_ok;
        o_prog_start |-> !$past(o_warning) && !$past(i_prog_busy) && $past(i_chan_ok)
            && $past(i_prog_cond);
    endproperty
    a_prog_ok: assert property (p_prog_ok) else $error("start not refused");
    property p_ot_flag;
        o_motor_stop |-> ##[0:2] (o_plus_entry_flag || o_minus_entry_flag);
    endproperty
    a_ot_flag: assert property (p_ot_flag) else $error("no entry flag");
    c_start: cover property (o_prog_start);
    c_estop: cover property ($fell(o_driver_ready));
    c_limit: cover property (o_motor_stop);
endmodule
bind sdci_ctrl sdci_ctrl_monitor #(
    .P_ESTOP_CYC(P_ESTOP_CYC), .P_FIRST_CYC(P_FIRST_CYC), .P_LATER_CYC(P_LATER_CYC)
) i_sdci_ctrl_monitor (.i_mclk, .i_rst, .i_pins, .i_prog_busy, .i_chan_ok, .i_prog_cond,
    .o_driver_ready, .o_warning, .o_servo_state, .o_plus_entry_flag, .o_minus_entry_flag,
    .o_dyn_brake, .o_motor_stop, .o_prog_start);

//--- tb/sdci_master_model.sv
`timescale 1ns/100ps
module sdci_master_model #(
    parameter int HOLD = 16
) (
    // clock
    input  wire logic                 i_mclk,
    // wanted levels, short estop order
    input  wire sdci_pkg::sdci_pins_t i_want,
    input  wire logic                 i_short,
    // pins to the driver
    output sdci_pkg::sdci_pins_t      o_pins
);
    import sdci_pkg::*;
    int hold_q = 0;
    initial o_pins = '0;
    // estop level kept HOLD cycles unless a glitch is ordered
    always @(posedge i_mclk) begin
        hold_q <= (hold_q > 0) ? hold_q - 1 : 0;
        o_pins <= i_want;
        if (i_want.emergency_stop != o_pins.emergency_stop) begin
            if (i_short || hold_q == 0) hold_q <= HOLD;
            else o_pins.emergency_stop <= o_pins.emergency_stop;
        end
    end
endmodule

//--- tb/servo_driver_control_inputs_tb.sv
`timescale 1ns/100ps
`define CK(t, e, s) begin cmp_count++; if ((e) !== (s)) begin bad_count++; \
    $display("wrong value %s exp %0h got %0h", t, e, s); end end
module servo_driver_control_inputs_tb;
    import sdci_pkg::*;
    localparam logic [TW-1:0] ES = 27'h8, FC = 27'h14, LC = 27'h6;
    logic          clk = 0, rst = 1, shrt = 0, mov = 0, mcw = 0, busy = 0, cok = 1, cnd = 1;
    logic          driver_ready_out, warning_out, svs, plus, minus, cstop, pst, mgo, mvcw, eclr;
    logic [7:0]    pch, exp_ch, chq[$];
    logic [31:0]   rd_q, lfsr = 32'h67C6;
    logic [1:0]    rr;
    int            bad_count = 0, cmp_count = 0, n, k, go_n = 0;
    sdci_pins_t    want, pins;
    sdci_wevt_t    wev = '0;
    sdci_axi_req_t axi = '0;
    sdci_axi_rsp_t rsp;
    sdci_code_t    wcode [6] = '{CODE_A3, CODE_A5, CODE_C0, CODE_F1, CODE_F8, CODE_P5};
    sdci_master_model #(.HOLD(16)) i_sdci_master_model (.i_mclk(clk), .i_want(want),
        .i_short(shrt), .o_pins(pins));
    sdci_ctrl #(.P_ESTOP_CYC(ES), .P_FIRST_CYC(FC), .P_LATER_CYC(LC)) i_sdci_ctrl (
        .i_mclk(clk), .i_rst(rst), .i_axi(axi), .o_axi(rsp), .i_pins(pins), .i_moving(mov),
        .i_motion_cw(mcw), .i_warn_evt(wev), .i_prog_busy(busy), .i_chan_ok(cok),
        .i_prog_cond(cnd), .o_driver_ready(driver_ready_out), .o_warning(warning_out), .o_servo_state(svs),
        .o_plus_entry_flag(plus), .o_minus_entry_flag(minus), .o_dyn_brake(),
        .o_err_clr(eclr), .o_cycle_stop(cstop), .o_motor_stop(), .o_prog_start(pst),
        .o_prog_chan(pch), .o_move_go(mgo), .o_move_cw(mvcw));
    initial forever #20 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // ----------------------------------------
    // program model: queue of accepted channels
    // ----------------------------------------
    always @(posedge clk) begin
        if (pst === 1'b1) begin
            `CK("stray start", 1'b1, chq.size() > 0)
            exp_ch = chq.pop_front();
            `CK("prog chan", exp_ch, pch)
        end
        if (mgo === 1'b1) go_n <= go_n + 1;
    end
    task automatic tally_and_finish;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int m);
        repeat (m) @(posedge clk);
    endtask
    task automatic wt(ref logic s, input logic v, input int lim);
        cmp_count++;
        for (n = 0; n < lim && s !== v; n++) @(negedge clk);
        if (s !== v) begin
            bad_count++;
            $display("wrong value wait exp %0h got %0h", v, s);
            tally_and_finish();
        end else @(posedge clk);
    endtask
    // ready sampled at negedge is what the next rising edge sees
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        logic aw = !rd, w = !rd, ar = rd;
        @(posedge clk);
        axi <= '{aw, a, w, d, 4'hF, aw, ar, a, ar};
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            rd_q = rsp.rdata;
            rr = rd ? rsp.rresp : rsp.bresp;
            if (rd ? !ar && rsp.rvalid : !aw && !w && rsp.bvalid) begin
                @(posedge clk);
                axi <= '0;
                return;
            end
            aw &= !rsp.awready;
            w &= !rsp.wready;
            ar &= !rsp.arready;
            @(posedge clk);
            axi.awvalid <= aw;
            axi.wvalid <= w;
            axi.arvalid <= ar;
        end
        bad_count++;
        tally_and_finish();
    endtask
    initial begin
        want = 17'h16300; // estop and limits closed, both supplies on
        cyc(5);
        rst <= 0;
        cyc(6);
        bus(1, ADDR_CFG, 0);
        `CK("cfg reset", 32'(CFG_RST), rd_q)
        bus(1, 8'h0C, 0);
        `CK("unmapped", RESP_SLVERR, rr)
        want.servo_request <= 1;
        wt(svs, 1, 60);
        `CK("first enable", 1'b1, n > 20)
        bus(0, ADDR_CMD, 1);
        wt(svs, 0, 8);
        bus(0, ADDR_CMD, 2);
        wt(svs, 1, 30);
        for (k = 0; k < 6; k++) begin
            if (k < 5) wev <= sdci_wevt_t'(5'h10 >> k);
            else want.main_power <= 0;
            cyc(1);
            wev <= '0;
            cyc(7);
            `CK("warn", 1'b1, warning_out)
            `CK("servo", 6'h12 >> k & 1, svs)
            `CK("cycle stop", k == 4, cstop)
            bus(1, ADDR_STAT, 0);
            `CK("warn code", wcode[k], rd_q[15:12])
            want.main_power <= 1;
            want.warning_clear <= 1;
            wt(warning_out, 0, 14);
            want.warning_clear <= 0;
            wt(svs, 1, 30);
            cyc(3);
        end
        for (k = 0; k < 5; k++) begin
            lfsr = xs(lfsr);
            want.channel_select <= lfsr[7:0];
            busy <= k == 1;
            cok <= k != 2;
            cnd <= k != 3;
            want.stop <= k == 4;
            want.warning_clear <= 1;
            cyc(4);
            if (k == 0) chq.push_back(lfsr[7:0]);
            want.program_start <= 1;
            cyc(8);
            bus(1, ADDR_STAT, 0);
            `CK("refused", k != 0, warning_out)
            `CK("f5 code", k ? CODE_F5 : CODE_NONE, rd_q[15:12])
            want.program_start <= 0;
            want.warning_clear <= 0;
            cyc(12);
            `CK("clear on fall", k != 0, warning_out)
            want.warning_clear <= 1;
            cyc(12);
            `CK("clear on rise", 1'b0, warning_out)
        end
        busy <= 0;
        cok <= 1;
        cnd <= 1;
        want.stop <= 0;
        `CK("starts left", 0, chq.size())
        mov <= 1;
        mcw <= 1;
        want.cw_limit <= 0;
        wt(plus, 1, 16);
        mov <= 0;
        `CK("minus flag", 1'b0, minus)
        `CK("servo lock", 1'b1, svs)
        bus(1, ADDR_STAT, 0);
        `CK("alarm", CODE_F3, rd_q[11:8])
        k = go_n;
        bus(0, ADDR_CMD, 32'h18);
        bus(0, ADDR_CMD, 32'h04);
        cyc(3);
        `CK("moves", k + 1, go_n)
        `CK("escape dir", 1'b0, mvcw)
        want.cw_limit <= 1;
        wt(plus, 0, 16);
        shrt <= 1;
        want.emergency_stop <= 0;
        cyc(3);
        want.emergency_stop <= 1;
        cyc(2);
        shrt <= 0;
        cyc(20);
        `CK("glitch", 1'b1, driver_ready_out)
        want.emergency_stop <= 0;
        wt(driver_ready_out, 0, 40);
        `CK("estop delay", 1'b1, n > 8)
        bus(0, ADDR_CMD, 2);
        bus(1, ADDR_STAT, 0);
        `CK("f4", CODE_F4, rd_q[11:8])
        `CK("servo off", 1'b0, svs)
        bus(0, ADDR_CFG, 1);
        wt(driver_ready_out, 1, 12);
        want.servo_request <= 0;
        wt(eclr, 1, 12);
        tally_and_finish();
    end
endmodule
